//--- rtl/acs_sequencer.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        cpuHaltedNr,
    input  wire logic        jtagEnable,
    input  wire logic [9:0]  coreResult,
    input  wire logic        coreOverRange,
    output logic             coreTick,
    output logic             coreStart,
    output logic             coreSample,
    output logic             coreDiff,
    output logic [4:0]       activeChannel,
    output logic [1:0]       activeRef,
    output logic             refIntOn,
    output logic             converterOn,
    output logic [7:0]       analogPinEn,
    output logic             doneIrq
);
    acs_sel_if sel ();
    acs_state_t state_r;
    acs_state_t state_nxt;

    logic        awready_r;
    logic        wready_r;
    logic [31:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    logic        enable_r;
    logic        freeRun_r;
    logic        irqEn_r;
    logic        done_r;
    logic [8:0]  divCnt_r;
    logic [4:0]  cnt_r;
    logic [4:0]  len_r;
    logic [4:0]  len_nxt;
    logic [9:0]  result_r;
    logic        halted_r;
    logic        jtagS1_r;
    logic        jtagS2_r;
    logic        coreTick_r;
    logic        coreStart_r;
    logic        coreSample_r;
    logic        coreDiff_r;
    logic        refIntOn_r;
    logic        converterOn_r;
    logic [7:0]  analogPinEn_r;
    logic        doneIrq_r;
    logic        halfClk;
    logic        tick;

    acs_sel_buf u_sel (
        .clk_sys (clk_sys),
        .rst     (rst),
        .sel     (sel.store)
    );

    acs_half_clk u_half (
        .clk_sys (clk_sys),
        .rst     (rst),
        .enable  (enable_r),
        .tick    (tick),
        .halfClk (halfClk)
    );

    // Bus decode
    wire        doWrite  = !awready_r && !wready_r && !bvalid_r;
    wire [31:0] wAddr    = {awAddr_r[31:2], 2'b00};
    wire [31:0] rAddr    = {s_axi_araddr[31:2], 2'b00};
    wire        wHitCtrl = wAddr == ADDR_CTRL;
    wire        wHitSel  = wAddr == ADDR_SEL;
    wire        wMapped  = wHitCtrl || wHitSel || wAddr == ADDR_STAT
                           || wAddr == ADDR_RES;
    wire        wrCtrl   = doWrite && wHitCtrl && wStrb_r[0];
    wire        wrSel    = doWrite && wHitSel && wStrb_r[0];
    wire        arTake   = s_axi_arvalid && arready_r;

    // Sequencing
    wire        stIdle    = state_r == ST_IDLE;
    wire        stArmed   = state_r == ST_ARMED;
    wire        stConv    = state_r == ST_CONV;
    assign tick = enable_r && divCnt_r == CONV_DIV - 9'h001;
    wire [4:0]  actCh     = sel.actSel[SEL_CH_LSB +: 5];
    wire [1:0]  actRf     = sel.actSel[SEL_REF_LSB +: 2];
    wire        diffAct   = acs_is_diff(actCh);
    wire        lastCyc   = stConv && cnt_r == len_r;
    wire        beginConv = stArmed && tick;
    wire        complete  = lastCyc && tick;
    wire        restart   = complete && freeRun_r;
    wire        swStart   = wrCtrl && wData_r[CTRL_START] && enable_r;
    wire        haltRise  = cpuHaltedNr && !halted_r;
    wire        sleepGo   = haltRise && enable_r && stIdle
                            && !freeRun_r && irqEn_r;
    wire        startBit  = !stIdle;
    wire [4:0]  shCnt     = len_r == LEN_SYNC ? SH_SYNC : SH_NORM;
    wire [4:0]  userLen   = (diffAct && halfClk) ? LEN_SYNC : LEN_NORM;
    wire [4:0]  autoLen   = diffAct ? LEN_SYNC : LEN_NORM;
    wire        clrDone   = wrCtrl && wData_r[CTRL_DONE];
    // Clamp follows the kind latched at launch, since the active
    // selection may already be refreshed in the final cycle
    wire [9:0]  capResult = (!coreDiff_r && coreOverRange) ? CODE_FULL
                                                           : coreResult;

    // Read data
    wire [31:0] ctrlRd;
    wire [31:0] statRd;
    assign ctrlRd[CTRL_EN]    = enable_r;
    assign ctrlRd[CTRL_START] = startBit;
    assign ctrlRd[CTRL_FREE]  = freeRun_r;
    assign ctrlRd[CTRL_IRQEN] = irqEn_r;
    assign ctrlRd[CTRL_DONE]  = done_r;
    assign ctrlRd[31:5]       = '0;
    assign statRd[7:0]        = sel.actSel;
    assign statRd[STAT_HALF]  = halfClk;
    assign statRd[STAT_BUSY]  = stConv;
    assign statRd[31:10]      = '0;
    wire        rMapped = rAddr == ADDR_CTRL || rAddr == ADDR_SEL
                          || rAddr == ADDR_STAT || rAddr == ADDR_RES;
    wire [31:0] rdMux   = rAddr == ADDR_CTRL ? ctrlRd
                        : rAddr == ADDR_SEL  ? {24'h0, sel.bufSel}
                        : rAddr == ADDR_STAT ? statRd
                        : rAddr == ADDR_RES  ? {22'h0, result_r}
                        : 32'h0000_0000;

    assign sel.wrEn   = wrSel;
    assign sel.wrData = wData_r[7:0];
    // Copy stops in the cycle a conversion is launched, so the
    // selection used to pick the length is the one that is frozen
    assign sel.copyEn = (stIdle || stArmed || lastCyc)
                        && !beginConv && !restart;

    // Write channel: address and data taken in either order
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awready_r <= 1'b1;
            awAddr_r  <= 32'h0000_0000;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            awAddr_r  <= s_axi_awaddr;
        end else if (doWrite) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wready_r <= 1'b1;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wData_r  <= s_axi_wdata;
            wStrb_r  <= s_axi_wstrb;
        end else if (doWrite) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= RESP_OKAY;
        end else if (arTake) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rdMux;
            rresp_r   <= rMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    // Control bits; enable is only ever cleared by software
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            enable_r  <= 1'b0;
            freeRun_r <= 1'b0;
            irqEn_r   <= 1'b0;
        end else if (wrCtrl) begin
            enable_r  <= wData_r[CTRL_EN];
            freeRun_r <= wData_r[CTRL_FREE];
            irqEn_r   <= wData_r[CTRL_IRQEN];
        end
    end

    // A completion in the clearing cycle wins over the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= complete || (done_r && !clrDone);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divCnt_r <= 9'h000;
        end else if (!enable_r || tick) begin
            divCnt_r <= 9'h000;
        end else begin
            divCnt_r <= divCnt_r + 9'h001;
        end
    end

    always_comb begin
        state_nxt = state_r;
        len_nxt   = len_r;
        unique case (state_r)
            ST_IDLE: begin
                if (swStart || sleepGo) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (beginConv) begin
                    state_nxt = ST_CONV;
                    len_nxt   = userLen;
                end
            end
            ST_CONV: begin
                if (restart) begin
                    len_nxt = autoLen;
                end else if (complete) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (!enable_r) begin
            state_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            len_r   <= LEN_NORM;
        end else begin
            state_r <= state_nxt;
            len_r   <= len_nxt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 5'h00;
        end else if (beginConv || restart) begin
            cnt_r <= 5'h01;
        end else if (stConv && tick) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            result_r <= 10'h000;
        end else if (complete) begin
            result_r <= capResult;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            halted_r <= 1'b0;
            jtagS1_r <= 1'b0;
            jtagS2_r <= 1'b0;
        end else begin
            halted_r <= cpuHaltedNr;
            jtagS1_r <= jtagEnable;
            jtagS2_r <= jtagS1_r;
        end
    end

    // Core strobes; sample point lands on the half-clock edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            coreTick_r   <= 1'b0;
            coreStart_r  <= 1'b0;
            coreSample_r <= 1'b0;
            coreDiff_r   <= 1'b0;
        end else begin
            coreTick_r   <= tick;
            coreStart_r  <= beginConv || restart;
            coreSample_r <= stConv && tick && cnt_r == shCnt;
            if (beginConv || restart) begin
                coreDiff_r <= diffAct;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            refIntOn_r    <= 1'b0;
            converterOn_r <= 1'b0;
            analogPinEn_r <= 8'h00;
            doneIrq_r     <= 1'b0;
        end else begin
            refIntOn_r    <= enable_r && actRf == REF_INT;
            converterOn_r <= enable_r;
            analogPinEn_r <= enable_r ? {{4{!jtagS2_r}}, 4'hf}
                                      : 8'h00;
            doneIrq_r     <= done_r && irqEn_r;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign coreTick      = coreTick_r;
    assign coreStart     = coreStart_r;
    assign coreSample    = coreSample_r;
    assign coreDiff      = coreDiff_r;
    assign activeChannel = actCh;
    assign activeRef     = actRf;
    assign refIntOn      = refIntOn_r;
    assign converterOn   = converterOn_r;
    assign analogPinEn   = analogPinEn_r;
    assign doneIrq       = doneIrq_r;
endmodule : acs_sequencer

//--- rtl/acs_pkg.sv
package acs_pkg;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_SEL  = 32'h0000_0004;
    localparam logic [31:0] ADDR_STAT = 32'h0000_0008;
    localparam logic [31:0] ADDR_RES  = 32'h0000_000c;

    localparam int CTRL_EN    = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_FREE  = 2;
    localparam int CTRL_IRQEN = 3;
    localparam int CTRL_DONE  = 4;
    localparam int STAT_HALF  = 8;
    localparam int STAT_BUSY  = 9;
    localparam int SEL_CH_LSB  = 0;
    localparam int SEL_REF_LSB = 6;

    localparam logic [7:0] SEL_RST  = 8'h00;
    localparam logic [7:0] SEL_MASK = 8'hdf;

    localparam logic [1:0] REF_EXT  = 2'h0;
    localparam logic [1:0] REF_AVCC = 2'h1;
    localparam logic [1:0] REF_RSVD = 2'h2;
    localparam logic [1:0] REF_INT  = 2'h3;

    localparam logic [4:0] CH_DIFF_LO = 5'h08;
    localparam logic [4:0] CH_BANDGAP = 5'h1e;

    localparam logic [4:0] LEN_NORM = 5'h0d;
    localparam logic [4:0] LEN_SYNC = 5'h0e;
    localparam logic [4:0] SH_NORM  = 5'h01;
    localparam logic [4:0] SH_SYNC  = 5'h02;
    localparam logic [9:0] CODE_FULL = 10'h3ff;

    localparam int CLK_SYS_HZ = 100_000_000;
    localparam int ADC_CLK_HZ = 200_000;
    localparam logic [8:0] CONV_DIV = 9'(CLK_SYS_HZ / ADC_CLK_HZ);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_CONV  = 3'b100
    } acs_state_t;

    function automatic logic acs_is_diff(input logic [4:0] ch);
        acs_is_diff = (ch >= CH_DIFF_LO) && (ch < CH_BANDGAP);
    endfunction : acs_is_diff
endpackage : acs_pkg

//--- rtl/acs_sel_if.sv
interface acs_sel_if;
    logic       wrEn;
    logic [7:0] wrData;
    logic       copyEn;
    logic [7:0] bufSel;
    logic [7:0] actSel;
    modport owner (output wrEn, output wrData, output copyEn,
                   input bufSel, input actSel);
    modport store (input wrEn, input wrData, input copyEn,
                   output bufSel, output actSel);
endinterface : acs_sel_if

//--- rtl/acs_sel_buf.sv
module acs_sel_buf
    import acs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    acs_sel_if.store sel
);
    logic [7:0] bufSel_r;
    logic [7:0] actSel_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bufSel_r <= SEL_RST;
        end else if (sel.wrEn) begin
            bufSel_r <= sel.wrData & SEL_MASK;
        end
    end

    // Frozen copy keeps the analog path stable while sampling
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            actSel_r <= SEL_RST;
        end else if (sel.copyEn) begin
            actSel_r <= bufSel_r;
        end
    end

    assign sel.bufSel = bufSel_r;
    assign sel.actSel = actSel_r;
endmodule : acs_sel_buf

//--- rtl/acs_half_clk.sv
module acs_half_clk (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic tick,
    output logic      halfClk
);
    logic halfClk_r;

    // Held low while off so the start phase is known
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            halfClk_r <= 1'b0;
        end else if (!enable) begin
            halfClk_r <= 1'b0;
        end else if (tick) begin
            halfClk_r <= ~halfClk_r;
        end
    end

    assign halfClk = halfClk_r;
endmodule : acs_half_clk

//--- test/acs_sequencer_asserts.sv
module acs_seq_asserts
    import acs_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       jtagEnable,
    input wire logic       coreTick,
    input wire logic       coreStart,
    input wire logic       coreSample,
    input wire logic       coreDiff,
    input wire logic [4:0] activeChannel,
    input wire logic [1:0] activeRef,
    input wire logic       refIntOn,
    input wire logic       converterOn,
    input wire logic [7:0] analogPinEn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] gapCnt_r;
    logic       gapOk_r;
    logic       holdSel_r;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Spacing is only trusted from the second tick after enable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gapCnt_r  <= 10'h000;
            gapOk_r   <= 1'b0;
            holdSel_r <= 1'b0;
        end else begin
            gapCnt_r  <= coreTick ? 10'h000 : gapCnt_r + 10'h001;
            gapOk_r   <= converterOn & (gapOk_r | coreTick);
            holdSel_r <= converterOn
                         & (coreStart | (holdSel_r & ~coreSample));
        end
    end

    sequence sLaunch;
        coreStart ##1 !coreStart;
    endsequence

    a_start_pulse: assert property (coreStart |-> sLaunch)
        else $error("launch pulse longer than one cycle");
    a_tick_gap: assert property (
        coreTick && gapOk_r |-> gapCnt_r == {1'b0, CONV_DIV} - 10'h001)
        else $error("converter tick spacing wrong");
    a_sel_frozen: assert property (
        holdSel_r && !coreSample |-> $stable({activeChannel, activeRef}))
        else $error("active selection moved during conversion");
    a_sample_bound: assert property (
        sLaunch |-> ##[0:1000] coreSample)
        else $error("sample instant missing after launch");
    a_diff_decode: assert property (sLaunch |-> coreDiff ==
        ((activeChannel >= CH_DIFF_LO) && (activeChannel < CH_BANDGAP)))
        else $error("differential flag does not match channel");
    a_ref_internal: assert property (
        $stable({converterOn, activeRef}) |->
        refIntOn == (converterOn && activeRef == REF_INT))
        else $error("internal reference enable wrong");
    a_jtag_pins: assert property (
        jtagEnable [*4] |-> analogPinEn[7:4] == 4'h0)
        else $error("upper analog pins not overridden");
    a_idle_quiet: assert property (
        !converterOn && !$past(converterOn) |-> !coreTick && !coreStart)
        else $error("converter activity while disabled");
endmodule : acs_seq_asserts

//--- test/acs_core_model.sv
module acs_core_model
    import acs_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       coreSample,
    input  wire logic [4:0] activeChannel,
    input  wire logic [1:0] activeRef,
    input  wire logic       overIn,
    output logic [9:0]      coreResult,
    output logic            coreOverRange
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held_r;
    logic [9:0] noise_r;
    logic       valid_r;

    // Before any sample the core output churns so stale data shows up
    assign coreResult = valid_r ? held_r : noise_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            held_r        <= 10'h000;
            noise_r       <= 10'h155;
            valid_r       <= 1'b0;
            coreOverRange <= 1'b0;
        end else begin
            noise_r <= ~noise_r;
            if (coreSample) begin
                held_r        <= {activeRef, 3'h0, activeChannel};
                valid_r       <= 1'b1;
                coreOverRange <= overIn;
            end
        end
    end
endmodule : acs_core_model

//--- test/test_adc_conversion_sequencer.sv
module test_adc_conversion_sequencer
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, cpuHaltedNr, jtagEnable, overIn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdv;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, coreOverRange, coreTick;
    logic        coreStart, coreSample, coreDiff, refIntOn, converterOn;
    logic        doneIrq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, activeRef, resp;
    logic [9:0]  coreResult;
    logic [4:0]  activeChannel;
    logic [7:0]  analogPinEn, selSh;
    int          errorCnt, comparisons, tickCnt, prevLen;
    logic [9:0]  expQ[$];

    acs_sequencer dut_u (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpuHaltedNr,
        .jtagEnable, .coreResult, .coreOverRange, .coreTick, .coreStart,
        .coreSample, .coreDiff, .activeChannel, .activeRef, .refIntOn,
        .converterOn, .analogPinEn, .doneIrq);
    acs_core_model core_u (.clk_sys, .rst, .coreSample, .activeChannel,
        .activeRef, .overIn, .coreResult, .coreOverRange);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Reference model: the buffered selection in force at launch decides
    always @(posedge clk_sys) begin
        if (coreStart) begin
            tickCnt <= 0;
            prevLen <= tickCnt + 1;
            expQ.push_back((overIn && !(selSh[4:0] >= 5'h08
                && selSh[4:0] < 5'h1e)) ? 10'h3ff
                : {selSh[7:6], 3'h0, selSh[4:0]});
        end else if (coreTick) begin
            tickCnt <= tickCnt + 1;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(s_axi_bvalid && !aw && !w));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [31:0] a);
        bit ar;
        ar = 1'b1;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end while (!(s_axi_rvalid && !ar));
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask : rd

    task automatic wait_done();
        int n;
        n = 0;
        while (doneIrq !== 1'b1 && n < 20000) begin
            @(posedge clk_sys);
            n++;
        end
        check(32'(doneIrq), 32'h1);
    endtask : wait_done

    // Result read, then the done flag is cleared by writing it back
    task automatic fin(input logic [31:0] ctrl);
        rd(ADDR_RES);
        check(rdv, 32'(expQ.pop_front()));
        wr(ADDR_CTRL, ctrl | 32'h10);
        check(32'(resp), 32'(RESP_OKAY));
        repeat (2) @(posedge clk_sys);
        check(32'(doneIrq), 32'h0);
    endtask : fin

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (90000) @(posedge clk_sys);
        errorCnt++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, cpuHaltedNr, jtagEnable} = 4'h0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hf;
        {overIn, selSh, errorCnt, comparisons, tickCnt, prevLen} = '0;
        void'($urandom(32'h60ecbe4d));
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) begin
            rd(32'(i * 4));
            check(rdv, 32'h0);
            check(32'(resp), 32'(i < 4 ? RESP_OKAY : RESP_SLVERR));
        end
        $display("test reset done");
        wr(ADDR_CTRL, 32'h1);
        for (int r = 0; r < 4; r++) begin
            selSh = {2'(r), 1'b0, 5'($urandom)};
            wr(ADDR_SEL, 32'(selSh | 8'h20));
            rd(ADDR_SEL);
            check(rdv, 32'(selSh));
            check(32'({activeRef, activeChannel}),
                32'({selSh[7:6], selSh[4:0]}));
            check(32'(refIntOn), 32'(r == 3));
        end
        $display("test selection done");
        selSh = 8'h42;
        wr(ADDR_SEL, 32'h42);
        overIn <= 1'b1;
        wr(ADDR_CTRL, 32'h0b);
        rd(ADDR_CTRL);
        check(32'(rdv[CTRL_START]), 32'h1);
        // Reselect only after a converter tick has passed
        repeat (600) @(posedge clk_sys);
        selSh = 8'h45;
        wr(ADDR_SEL, 32'h45);
        check(32'(activeChannel), 32'h02);
        wait_done();
        check(32'(tickCnt), 32'd13);
        check(32'(activeChannel), 32'h05);
        rd(ADDR_CTRL);
        check(32'(rdv[4:0]), 32'h19);
        fin(32'h09);
        $display("test single conversion done");
        selSh = 8'h49;
        wr(ADDR_SEL, 32'h49);
        // Gain stage settling before any differential start
        repeat (12500) @(posedge clk_sys);
        for (int ph = 0; ph < 2; ph++) begin
            forever begin
                @(posedge clk_sys);
                if (coreTick) begin
                    repeat (5) @(posedge clk_sys);
                    rd(ADDR_STAT);
                    if (rdv[STAT_HALF] == ph[0]) break;
                end
            end
            wr(ADDR_CTRL, 32'h0b);
            wait_done();
            check(32'(tickCnt), 32'(13 + ph));
            fin(32'h09);
        end
        $display("test differential done");
        wr(ADDR_CTRL, 32'h0f);
        for (int k = 0; k < 3; k++) begin
            wait_done();
            if (k > 0) check(32'(prevLen), 32'd14);
            if (k == 0) begin
                selSh = 8'h4a;
                wr(ADDR_SEL, 32'h4a);
            end
            fin(32'h0d);
        end
        // Let the running conversion pass its sample point first
        repeat (1100) @(posedge clk_sys);
        wr(ADDR_CTRL, 32'h0);
        expQ.delete();
        rd(ADDR_STAT);
        check(32'(rdv[STAT_HALF]), 32'h0);
        $display("test free run done");
        selSh = 8'h43;
        wr(ADDR_SEL, 32'h43);
        overIn <= 1'b0;
        wr(ADDR_CTRL, 32'h01);
        cpuHaltedNr <= 1'b1;
        repeat (1200) @(posedge clk_sys);
        check(32'(expQ.size()), 32'h0);
        cpuHaltedNr <= 1'b0;
        wr(ADDR_CTRL, 32'h09);
        cpuHaltedNr <= 1'b1;
        repeat (1200) @(posedge clk_sys);
        cpuHaltedNr <= 1'b0;
        wait_done();
        check(32'(tickCnt), 32'd13);
        check(32'(converterOn), 32'h1);
        fin(32'h09);
        jtagEnable <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check(32'(analogPinEn[7:4]), 32'h0);
        jtagEnable <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check(32'(analogPinEn), 32'hff);
        $display("test sleep start done");
        final_report();
    end
endmodule : test_adc_conversion_sequencer

bind acs_sequencer acs_seq_asserts chk_u (.clk_sys, .rst, .jtagEnable,
    .coreTick, .coreStart, .coreSample, .coreDiff, .activeChannel,
    .activeRef, .refIntOn, .converterOn, .analogPinEn);
